// [wdt_pkg.sv]
// wdt_pkg: constants and types for the watchdog timer block
// assumes a 10 MHz system clock; oscillator ticks come in as an enable
package wdt_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] WDT_CONTROL_ADDR = 4'h0;
    localparam logic [3:0] WDT_STATUS_ADDR = 4'h4;
    localparam logic [7:0] WDT_CONTROL_RESET = 8'h7F;
    localparam int WDT_ACT_BIT = 7;
    localparam int WDT_T6_BIT = 6;
    localparam logic [1:0] WDT_RESP_OKAY = 2'h0;
    localparam logic [1:0] WDT_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int WDT_PRESCALE_CYCLES = 16384;
    localparam int WDT_PRESCALE_W = 14;
    localparam int WDT_CLOCK_MHZ = 10;
    localparam int WDT_PULSE_US = 30;
    localparam int WDT_PULSE_CYCLES = WDT_PULSE_US * WDT_CLOCK_MHZ;
    localparam int WDT_PULSE_W = 9;
    localparam logic [6:0] WDT_ROLL_FROM = 7'h40;

    // prescaler phase offset per timebase (LSB column, in 64-tick units)
    localparam logic [7:0] WDT_PHASE_TB0 = 8'h3B;
    localparam logic [7:0] WDT_PHASE_TB1 = 8'h35;
    localparam logic [7:0] WDT_PHASE_TB2 = 8'h23;
    localparam logic [7:0] WDT_PHASE_TB3 = 8'h36;

    typedef enum logic [1:0] {
        WDT_TB_2MS = 2'b00,
        WDT_TB_4MS = 2'b01,
        WDT_TB_10MS = 2'b10,
        WDT_TB_25MS = 2'b11
    } wdt_tb_t;

    typedef enum logic [0:0] {
        WDT_RUN = 1'b0,
        WDT_PULSE = 1'b1
    } wdt_state_t;

    typedef struct packed {
        logic hw_enable;
        logic halt_reset_option;
    } wdt_options_t;

endpackage

// [wdt_top.sv]
// wdt_top: watchdog counter, prescaler, reset pulse and AXI4-Lite slave
// assumes option bits are stable straps and halt request is a pulse
//
// What this block does
// - counter decrements once per 16384 oscillator cycles of the prescaler.
// - if activated, rollover 40h to 3Fh starts a reset pulse of 30 us.
// - counter keeps decrementing even while the watchdog is not activated.
// - reset clears activation; writes cannot clear it once set.
// - write with activation set and bit 6 clear resets immediately.
// - halt while activated causes reset instead of halt mode.
// - low six bits give the timeout in prescaler steps, from 1 to 64.
// - a register write does not restart the prescaler.
// - a power-up option makes the watchdog active in hardware.
// - prescaler phase depends on the 2-bit clock timebase select.
// - an option bit decides whether halt produces a watchdog reset.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module wdt_top (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // oscillator tick and chip context
    input wire logic osc_tick_in,
    input wire wdt_pkg::wdt_tb_t timebase_select_in,
    input wire wdt_pkg::wdt_options_t options_in,
    input wire logic halt_req_in,
    // axi4-lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // reset and halt outputs
    output logic wdt_reset_out,
    output logic reset_pin_n_out,
    output logic halt_enter_out
);
    import wdt_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] control;
    logic [WDT_PRESCALE_W-1:0] prescale;
    logic [WDT_PULSE_W-1:0] pulse_cnt;
    wdt_state_t state;
    logic opt_hw;
    logic opt_halt;
    logic strap_done;
    logic [3:0] aw_addr;
    logic aw_have;
    logic [7:0] w_data;
    logic w_have;
    logic w_lane0;
    logic [31:0] next_rdata;
    logic [WDT_PRESCALE_W-1:0] phase;
    logic step;
    logic active;
    logic wr_fire;
    logic wr_ctrl;
    logic [7:0] next_control;
    logic trig_roll;
    logic trig_soft;
    logic trig_halt;

    // ------------------------------------------------------------
    // straps, caught after reset release
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            strap_done <= 1'b0;
            opt_hw <= 1'b0;
            opt_halt <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            opt_hw <= options_in.hw_enable;
            opt_halt <= options_in.halt_reset_option;
        end
    end

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    // phase offset aligns the step with the clock controller timebase
    always_comb begin
        case (timebase_select_in)
            WDT_TB_2MS: phase = {WDT_PHASE_TB0, 6'h00};
            WDT_TB_4MS: phase = {WDT_PHASE_TB1, 6'h00};
            WDT_TB_10MS: phase = {WDT_PHASE_TB2, 6'h00};
            WDT_TB_25MS: phase = {WDT_PHASE_TB3, 6'h00};
            default: phase = '0;
        endcase
    end

    // free-running; never cleared by writes, so first step jitters
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            prescale <= '0;
        end else if (osc_tick_in) begin
            prescale <= prescale + 1'b1;
        end
    end

    assign step = osc_tick_in &&
        (prescale == phase - 1'b1);

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_have && !s_axi_bvalid;
    assign s_axi_wready = !w_have && !s_axi_bvalid;
    assign wr_fire = aw_have && w_have && !s_axi_bvalid;
    assign wr_ctrl = wr_fire && aw_addr == WDT_CONTROL_ADDR && w_lane0;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= WDT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == WDT_CONTROL_ADDR ||
                    aw_addr == WDT_STATUS_ADDR) ?
                    WDT_RESP_OKAY : WDT_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // counter and activation
    // ------------------------------------------------------------
    always_comb begin
        next_control = control;
        if (step) begin
            next_control[6:0] = control[6:0] - 7'h01;
        end
        if (wr_ctrl) begin
            next_control[6:0] = w_data[6:0];
            // sticky: a write may set activation but never clear it
            next_control[WDT_ACT_BIT] = control[WDT_ACT_BIT] |
                w_data[WDT_ACT_BIT];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            control <= WDT_CONTROL_RESET;
        end else if (state == WDT_PULSE) begin
            control <= WDT_CONTROL_RESET;
        end else begin
            control <= next_control;
        end
    end

    assign active = control[WDT_ACT_BIT] || opt_hw;
    assign trig_roll = active && step && !wr_ctrl &&
        control[6:0] == WDT_ROLL_FROM;
    assign trig_soft = wr_ctrl && w_data[WDT_ACT_BIT] &&
        !w_data[WDT_T6_BIT];
    assign trig_halt = halt_req_in && active && opt_halt;
    // halt proceeds only when it does not turn into a reset
    assign halt_enter_out = halt_req_in && !trig_halt;

    // ------------------------------------------------------------
    // reset pulse
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state <= WDT_RUN;
            pulse_cnt <= '0;
        end else begin
            case (state)
                WDT_RUN: begin
                    if (trig_roll || trig_soft || trig_halt) begin
                        state <= WDT_PULSE;
                        pulse_cnt <= WDT_PULSE_W'(WDT_PULSE_CYCLES - 1);
                    end
                end
                WDT_PULSE: begin
                    if (pulse_cnt == '0) begin
                        state <= WDT_RUN;
                    end else begin
                        pulse_cnt <= pulse_cnt - 1'b1;
                    end
                end
                default: state <= WDT_RUN;
            endcase
        end
    end

    assign wdt_reset_out = (state == WDT_PULSE);
    assign reset_pin_n_out = !wdt_reset_out;

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        case (s_axi_araddr)
            WDT_CONTROL_ADDR: next_rdata = {24'h000000, control};
            WDT_STATUS_ADDR: next_rdata = {28'h0000000, opt_halt, opt_hw,
                active, wdt_reset_out};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= WDT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= (s_axi_araddr == WDT_CONTROL_ADDR ||
                s_axi_araddr == WDT_STATUS_ADDR) ?
                WDT_RESP_OKAY : WDT_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// [wdt_top_asserts.sv]
// wdt_top_asserts: port-level checks on the watchdog block
// assumes one clock domain and the wdt_pkg encodings
`timescale 1ns/1ps
module wdt_top_asserts (
    // clock and context
    input wire logic clock_in,
    input wire logic rst_in,
    input wire wdt_pkg::wdt_options_t options_in,
    input wire logic halt_req_in,
    // axi4-lite
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // reset and halt outputs
    input wire logic wdt_reset_out,
    input wire logic reset_pin_n_out,
    input wire logic halt_enter_out
);
    import wdt_pkg::*;
    logic [8:0] hi_cnt;
    logic [3:0] wa_q;
    logic [7:0] wd_q;
    // -------------------------------------------------
    // helpers
    // -------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in || !wdt_reset_out) hi_cnt <= 9'h000;
        else hi_cnt <= hi_cnt + 9'h001;
    end
    always_ff @(posedge clock_in) begin
        if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
    end
    // a write without byte 0 can never trigger a soft reset
    always_ff @(posedge clock_in) begin
        if (s_axi_wvalid && s_axi_wready)
            wd_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'hFF;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence s_soft_wr;
        $rose(s_axi_bvalid) && wa_q == WDT_CONTROL_ADDR && wd_q[7:6] == 2'h2;
    endsequence
    sequence s_pulse_end;
        $fell(wdt_reset_out);
    endsequence
    sequence s_halt_free;
        halt_req_in && !options_in.halt_reset_option;
    endsequence
    sequence s_bad_rd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr != WDT_CONTROL_ADDR
            && s_axi_araddr != WDT_STATUS_ADDR;
    endsequence
    // -------------------------------------------------
    // checks
    // -------------------------------------------------
    a_soft_rst: assert property (s_soft_wr |-> ##[0:2] wdt_reset_out)
        else $error("soft reset missing");
    a_pulse_len: assert property (s_pulse_end |-> hi_cnt == 300)
        else $error("pulse length wrong");
    a_pulse_max: assert property (hi_cnt <= 9'h12C)
        else $error("pulse too long");
    a_pin_inv: assert property (reset_pin_n_out == !wdt_reset_out)
        else $error("reset pin not inverse");
    a_halt_opt: assert property (s_halt_free |-> halt_enter_out)
        else $error("halt converted without option");
    a_ar_ready: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during rvalid");
    a_rd_err: assert property (s_bad_rd |=> s_axi_rvalid
        && s_axi_rresp == WDT_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_wr_err: assert property ($rose(s_axi_bvalid) && wa_q[1:0] == 2'h0
        && wa_q[3] |-> s_axi_bresp == WDT_RESP_SLVERR)
        else $error("unmapped write not refused");
endmodule
bind wdt_top wdt_top_asserts wdt_top_asserts_inst (.clock_in, .rst_in,
    .options_in, .halt_req_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .wdt_reset_out,
    .reset_pin_n_out, .halt_enter_out);

// [test_windowless_watchdog_timer.sv]
// test_windowless_watchdog_timer: directed register-level bench
// assumes wdt_top with osc ticks every clock, 2ms timebase up to the final 10ms phase check
`timescale 1ns/1ps
module test_windowless_watchdog_timer;
    import wdt_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic osc_tick_in = 1'b1;
    wdt_tb_t timebase_select_in = WDT_TB_2MS;
    wdt_options_t options_in = 2'h1;
    logic halt_req_in = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'hF, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, h;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, wdt_reset_out, reset_pin_n_out, halt_enter_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int fail_count = 0;
    int cmp_count = 0;
    int n;
    wdt_top wdt_top_inst (.clock_in, .rst_in, .osc_tick_in,
        .timebase_select_in, .options_in, .halt_req_in, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .wdt_reset_out, .reset_pin_n_out, .halt_enter_out);
    always #50 clock_in = ~clock_in;
    // -------------------------------------------------
    // tasks
    // -------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        logic ta, tw, tb;
        int k;
        k = 0;
        tb = 1'b0;
        @(posedge clock_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb && k < 50) begin
            @(negedge clock_in);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clock_in);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            k++;
        end
        s_axi_bready <= 1'b0;
        chk("write done", 1'b1, tb);
    endtask
    task automatic rd(input logic [3:0] a);
        logic ta, tr;
        int k;
        k = 0;
        tr = 1'b0;
        @(posedge clock_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tr && k < 50) begin
            @(negedge clock_in);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clock_in);
            if (ta) s_axi_arvalid <= 1'b0;
            k++;
        end
        s_axi_rready <= 1'b0;
    endtask
    // bounded waits on the reset output, n holds cycles seen
    task automatic wait_hi(input int lim);
        for (n = 0; wdt_reset_out !== 1'b1 && n < lim; n++)
            @(negedge clock_in);
    endtask
    task automatic hold();
        for (n = 0; wdt_reset_out === 1'b1 && n < 400; n++)
            @(negedge clock_in);
    endtask
    task automatic halt_pulse();
        @(posedge clock_in);
        halt_req_in <= 1'b1;
        @(negedge clock_in);
        h = halt_enter_out;
        @(posedge clock_in);
        halt_req_in <= 1'b0;
    endtask
    task automatic do_reset(input wdt_options_t o);
        @(posedge clock_in);
        rst_in <= 1'b1;
        options_in <= o;
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
    endtask
    task automatic conclude();
        $display("TB: compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // -------------------------------------------------
    // sequence
    // -------------------------------------------------
    initial begin
        do_reset(2'h1);
        rd(WDT_CONTROL_ADDR);
        chk("control", 32'h7F, d);
        rd(4'h8);
        chk("rresp", WDT_RESP_SLVERR, r);
        wr(4'h8, 8'h00);
        chk("bresp", WDT_RESP_SLVERR, r);
        // poll from the reset value; the unmapped read left d at zero
        d = 32'h7F;
        for (n = 0; d === 32'h7F && n < 9000; n++) rd(WDT_CONTROL_ADDR);
        chk("decrement", 32'h7E, d);
        halt_pulse();
        chk("halt entry", 1'b1, h);
        wr(WDT_CONTROL_ADDR, 8'h80);
        wait_hi(5);
        chk("soft reset", 1'b0, reset_pin_n_out);
        hold();
        chk("pulse width", 300, n);
        rd(WDT_CONTROL_ADDR);
        chk("after pulse", 32'h7F, d);
        wr(WDT_CONTROL_ADDR, 8'hC1);
        wr(WDT_CONTROL_ADDR, 8'h41);
        rd(WDT_CONTROL_ADDR);
        chk("sticky", 2'h3, d[7:6]);
        wait_hi(33000);
        chk("min timeout", 1'b1, d !== 32'hC1 || n > 16370);
        chk("max timeout", 1'b1, wdt_reset_out && n <= 32790);
        hold();
        wr(WDT_CONTROL_ADDR, 8'hC0);
        halt_pulse();
        chk("halt blocked", 1'b0, h);
        wait_hi(5);
        chk("halt reset", 1'b1, wdt_reset_out);
        hold();
        do_reset(2'h2);
        rd(WDT_STATUS_ADDR);
        chk("hw option", 1'b1, d[2]);
        wr(WDT_CONTROL_ADDR, 8'h40);
        halt_pulse();
        chk("halt free", 1'b1, h);
        wait_hi(16500);
        chk("hw watchdog", 1'b1, wdt_reset_out);
        hold();
        do_reset(2'h2);
        // 10ms timebase: first step lands 35*64 ticks after release
        timebase_select_in <= WDT_TB_10MS;
        wr(WDT_CONTROL_ADDR, 8'h40);
        wait_hi(3000);
        chk("tb phase", 1'b1, n > 2200 && n <= 2240);
        conclude();
    end
    initial begin
        #8000000;
        fail_count++;
        conclude();
    end
endmodule
